/* File: include/ppr_pkg.sv */
/*
 Package for the peripheral pin remap slice: register indices, field
 positions, reset values, encodings and carrier structs.
 Assumes a classic Wishbone slave with 32-bit data on a 25 MHz clock.
*/
// Summary of operation
// - Code zero ties peripheral input to ground
// - Code one drives input from comparator
// - Top code selects input-only pin 121
// - Unimplemented bits ignore writes, read zero
// - Low 7-bit field selects SPI2 slave-select
// - Low 7-bit field selects CAN1 receive
// - First output map: pins 35 and 20
// - Second output map: pins 37 and 36
// - Third output map: pins 39 and 38
// - Fourth output map: pins 41 and 40
// - Fifth output map: pins 43 and 42
// - Sixth output map: pins 55 and 54
// - Seventh output map: pins 57 and 56
// - Pin 97 upper field only
// - Pin 118 upper field only
// - Pin 120 low field only
package ppr_pkg;
   // ****************************************************
   // Register map (byte address = 4 * index)
   // ****************************************************
   localparam int PPR_NREG = 15;
   localparam logic [3:0] PPR_IDX_SPI2 = 4'h0;
   localparam logic [3:0] PPR_IDX_CAN1 = 4'h1;
   localparam logic [3:0] PPR_IDX_SYNC = 4'h2;
   localparam logic [3:0] PPR_IDX_DTC1 = 4'h3;
   localparam logic [3:0] PPR_IDX_DTC23 = 4'h4;
   localparam logic [3:0] PPR_IDX_OUT0 = 4'h5;
   localparam logic [3:0] PPR_IDX_OUT7 = 4'hc;
   localparam logic [3:0] PPR_IDX_OUT8 = 4'hd;
   localparam logic [3:0] PPR_IDX_OUT9 = 4'he;
   // Write masks of implemented bits per register
   localparam logic [15:0] PPR_MASK_LO7 = 16'h007f;
   localparam logic [15:0] PPR_MASK_HI7 = 16'h7f00;
   localparam logic [15:0] PPR_MASK_BOTH7 = 16'h7f7f;
   localparam logic [15:0] PPR_MASK_BOTH6 = 16'h3f3f;
   localparam logic [15:0] PPR_MASK_HI6 = 16'h3f00;
   localparam logic [15:0] PPR_MASK_LO6 = 16'h003f;
   localparam logic [15:0] PPR_RESET = 16'h0000;
   localparam int PPR_HI_POS = 8;
   // ****************************************************
   // Input-select encoding
   // ****************************************************
   localparam logic [6:0] PPR_SEL_GND = 7'h00;
   localparam logic [6:0] PPR_SEL_CMP = 7'h01;
   localparam logic [6:0] PPR_SEL_PIN121 = 7'h79;
   localparam int PPR_NOUT = 18;
   localparam int PPR_NFUNC = 64;
   localparam logic [5:0] PPR_FN_PORT = 6'h00;
   typedef struct packed {
      logic spi2_slave_select_input;
      logic can1_receive_input;
      logic pwm_sync_input;
      logic [2:0] deadtime_comp_input;
   } ppr_in_t;
endpackage

/* File: logic/ppr_remap.sv */
/*
 Peripheral pin remap slice: select registers on a Wishbone slave,
 input routing to peripherals and output routing to remappable pins.
 Assumes pins and comparator are asynchronous; functions are on clk_i.
*/
`timescale 1ns/1ps
module ppr_remap
   import ppr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [127:0] remappable_pin_i,
   input wire logic first_comparator_output_i,
   input wire logic [ppr_pkg::PPR_NFUNC-1:0] func_out_i,
   output ppr_pkg::ppr_in_t periph_in_o,
   output logic [ppr_pkg::PPR_NOUT-1:0] pin_out_o,
   output logic [ppr_pkg::PPR_NOUT-1:0] pin_remap_en_o
);
   import ppr_pkg::*;

   // ****************************************************
   // Register file
   // ****************************************************
   logic [15:0] map_reg [PPR_NREG];
   logic [127:0] pin_meta_reg, pin_sync_reg;
   logic cmp_meta_reg, cmp_sync_reg;
   logic [3:0] idx;
   logic hit;
   logic [15:0] wmask;

   function automatic logic [15:0] impl_mask(input logic [3:0] i);
      if (i == PPR_IDX_SPI2 || i == PPR_IDX_CAN1) begin
         return PPR_MASK_LO7;
      end else if (i == PPR_IDX_SYNC || i == PPR_IDX_DTC1) begin
         return PPR_MASK_HI7;
      end else if (i == PPR_IDX_DTC23) begin
         return PPR_MASK_BOTH7;
      end else if (i == PPR_IDX_OUT7 || i == PPR_IDX_OUT8) begin
         return PPR_MASK_HI6;
      end else if (i == PPR_IDX_OUT9) begin
         return PPR_MASK_LO6;
      end else begin
         return PPR_MASK_BOTH6;
      end
   endfunction

   // Common input encoding, shared by all six input fields
   function automatic logic route_in(input logic [6:0] code, input logic [127:0] pins,
                                     input logic cmp);
      if (code == PPR_SEL_GND) begin
         return 1'b0;
      end else if (code == PPR_SEL_CMP) begin
         return cmp;
      end else if (code > PPR_SEL_PIN121) begin
         return 1'b0;
      end else begin
         return pins[code];
      end
   endfunction

   assign idx = wb_adr_i[5:2];
   assign hit = idx < 4'(PPR_NREG);
   // A function result cannot be part-selected, so the mask is a net
   assign wmask = impl_mask(idx);

   // Mask stops writes to unimplemented bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < PPR_NREG; i++) begin
            map_reg[i] <= PPR_RESET;
         end
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && hit) begin
         for (int b = 0; b < 2; b++) begin
            if (wb_sel_i[b]) begin
               map_reg[idx][b*8 +: 8] <= wb_dat_i[b*8 +: 8] & wmask[b*8 +: 8];
            end
         end
      end
   end

   // One ack, registered a cycle after the request; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= (hit && !wb_we_i) ? {16'h0000, map_reg[idx]} : 32'h0000_0000;
      end
   end

   // ****************************************************
   // Input routing
   // ****************************************************
   // Pins are asynchronous: two flops before any selector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= remappable_pin_i;
         pin_sync_reg <= pin_meta_reg;
         cmp_meta_reg <= first_comparator_output_i;
         cmp_sync_reg <= cmp_meta_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_in_o <= '0;
      end else begin
         periph_in_o.spi2_slave_select_input <=
            route_in(map_reg[PPR_IDX_SPI2][6:0], pin_sync_reg, cmp_sync_reg);
         periph_in_o.can1_receive_input <=
            route_in(map_reg[PPR_IDX_CAN1][6:0], pin_sync_reg, cmp_sync_reg);
         periph_in_o.pwm_sync_input <=
            route_in(map_reg[PPR_IDX_SYNC][14:8], pin_sync_reg, cmp_sync_reg);
         periph_in_o.deadtime_comp_input[0] <=
            route_in(map_reg[PPR_IDX_DTC1][14:8], pin_sync_reg, cmp_sync_reg);
         periph_in_o.deadtime_comp_input[1] <=
            route_in(map_reg[PPR_IDX_DTC23][6:0], pin_sync_reg, cmp_sync_reg);
         periph_in_o.deadtime_comp_input[2] <=
            route_in(map_reg[PPR_IDX_DTC23][14:8], pin_sync_reg, cmp_sync_reg);
      end
   end

   // ****************************************************
   // Output routing
   // ****************************************************
   // Pin order: 20,35,36,37,38,39,40,41,42,43,54,55,56,57,97,118,120
   // plus a spare slot 17 that never remaps
   logic [5:0] code_w [PPR_NOUT];
   always_comb begin
      code_w[0] = map_reg[PPR_IDX_OUT0][5:0];
      code_w[1] = map_reg[PPR_IDX_OUT0][13:8];
      code_w[2] = map_reg[PPR_IDX_OUT0 + 4'h1][5:0];
      code_w[3] = map_reg[PPR_IDX_OUT0 + 4'h1][13:8];
      code_w[4] = map_reg[PPR_IDX_OUT0 + 4'h2][5:0];
      code_w[5] = map_reg[PPR_IDX_OUT0 + 4'h2][13:8];
      code_w[6] = map_reg[PPR_IDX_OUT0 + 4'h3][5:0];
      code_w[7] = map_reg[PPR_IDX_OUT0 + 4'h3][13:8];
      code_w[8] = map_reg[PPR_IDX_OUT0 + 4'h4][5:0];
      code_w[9] = map_reg[PPR_IDX_OUT0 + 4'h4][13:8];
      code_w[10] = map_reg[PPR_IDX_OUT0 + 4'h5][5:0];
      code_w[11] = map_reg[PPR_IDX_OUT0 + 4'h5][13:8];
      code_w[12] = map_reg[PPR_IDX_OUT0 + 4'h6][5:0];
      code_w[13] = map_reg[PPR_IDX_OUT0 + 4'h6][13:8];
      code_w[14] = map_reg[PPR_IDX_OUT7][13:8];
      code_w[15] = map_reg[PPR_IDX_OUT8][13:8];
      code_w[16] = map_reg[PPR_IDX_OUT9][5:0];
      code_w[17] = PPR_FN_PORT;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_o <= '0;
         pin_remap_en_o <= '0;
      end else begin
         for (int p = 0; p < PPR_NOUT; p++) begin
            // Port-owned and spare slots read low, never function zero
            pin_out_o[p] <= (code_w[p] != PPR_FN_PORT) && func_out_i[code_w[p]];
            pin_remap_en_o[p] <= code_w[p] != PPR_FN_PORT;
         end
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence ack_pulse_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   AST_GND_CODE: assert property (map_reg[PPR_IDX_SPI2][6:0] == PPR_SEL_GND
      |=> !periph_in_o.spi2_slave_select_input) else $error("spi2 not grounded");
   AST_CMP_CODE: assert property (map_reg[PPR_IDX_CAN1][6:0] == PPR_SEL_CMP
      |=> periph_in_o.can1_receive_input == $past(cmp_sync_reg)) else $error("cmp route");
   AST_PIN121: assert property (map_reg[PPR_IDX_SYNC][14:8] == PPR_SEL_PIN121
      |=> periph_in_o.pwm_sync_input == $past(pin_sync_reg[121])) else $error("pin121");
   AST_UNIMPL_ZERO: assert property ((map_reg[PPR_IDX_SPI2] & ~PPR_MASK_LO7) == 16'h0000
      && (map_reg[PPR_IDX_OUT9] & ~PPR_MASK_LO6) == 16'h0000) else $error("unimpl bit set");
   AST_WRITE_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> ack_pulse_s)
      else $error("ack timing");
   AST_OUT0_LO: assert property (map_reg[PPR_IDX_OUT0][5:0] != PPR_FN_PORT
      |=> pin_remap_en_o[0]) else $error("pin20 not remapped");
   AST_PIN97: assert property (map_reg[PPR_IDX_OUT7][13:8] == PPR_FN_PORT
      |=> !pin_remap_en_o[14]) else $error("pin97 remapped");
   AST_PIN120: assert property ((map_reg[PPR_IDX_OUT9][5:0] == 6'h01)
      |=> pin_out_o[16] == $past(func_out_i[1])) else $error("pin120 function");
   AST_DTC2: assert property (map_reg[PPR_IDX_DTC23][6:0] == PPR_SEL_GND
      |=> !periph_in_o.deadtime_comp_input[1]) else $error("dtc2 not grounded");

   // ****************************************************
   // Reset and bus checks
   // ****************************************************
   // Reset checks run while reset is high, so they opt out of the default
   AST_RST_CLEARS: assert property (disable iff (1'b0) rst_i
      |=> !wb_ack_o && periph_in_o == '0 && pin_remap_en_o == '0 && pin_out_o == '0)
      else $error("reset left an output set");
   AST_RST_MAP: assert property (disable iff (1'b0) rst_i
      |=> map_reg[PPR_IDX_SPI2] == PPR_RESET && map_reg[PPR_IDX_DTC23] == PPR_RESET
         && map_reg[PPR_IDX_OUT9] == PPR_RESET) else $error("map not cleared");
   AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   AST_RD_UPPER: assert property (wb_dat_o[31:16] == 16'h0000)
      else $error("upper read half set");
   AST_RD_UNMAPPED: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !hit
      |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
   AST_RD_DATA: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && hit && !wb_ack_o
      |=> wb_dat_o[15:0] == $past(map_reg[idx])) else $error("read data wrong");
   AST_WR_LANDS: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
      && idx == PPR_IDX_SPI2 && wb_sel_i[0]
      |=> map_reg[PPR_IDX_SPI2][6:0] == $past(wb_dat_i[6:0])) else $error("spi2 write lost");
   AST_WR_LANE_HOLD: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
      && idx == PPR_IDX_DTC23 && !wb_sel_i[1]
      |=> map_reg[PPR_IDX_DTC23][15:8] == $past(map_reg[PPR_IDX_DTC23][15:8]))
      else $error("disabled lane written");

   // ****************************************************
   // Unimplemented bits
   // ****************************************************
   // Masks come from the package, apart from impl_mask, so a slip there shows
   AST_UNIMPL_CAN1: assert property ((map_reg[PPR_IDX_CAN1] & ~PPR_MASK_LO7)
      == 16'h0000) else $error("can1 unimpl bit set");
   AST_UNIMPL_SYNC: assert property ((map_reg[PPR_IDX_SYNC] & ~PPR_MASK_HI7)
      == 16'h0000) else $error("sync unimpl bit set");
   AST_UNIMPL_DTC1: assert property ((map_reg[PPR_IDX_DTC1] & ~PPR_MASK_HI7)
      == 16'h0000) else $error("dtc1 unimpl bit set");
   AST_UNIMPL_DTC23: assert property ((map_reg[PPR_IDX_DTC23] & ~PPR_MASK_BOTH7)
      == 16'h0000) else $error("dtc23 unimpl bit set");
   AST_UNIMPL_OUT0: assert property ((map_reg[PPR_IDX_OUT0] & ~PPR_MASK_BOTH6)
      == 16'h0000) else $error("out0 unimpl bit set");
   AST_UNIMPL_OUT1: assert property ((map_reg[PPR_IDX_OUT0 + 4'h1] & ~PPR_MASK_BOTH6)
      == 16'h0000) else $error("out1 unimpl bit set");
   AST_UNIMPL_OUT2: assert property ((map_reg[PPR_IDX_OUT0 + 4'h2] & ~PPR_MASK_BOTH6)
      == 16'h0000) else $error("out2 unimpl bit set");
   AST_UNIMPL_OUT3: assert property ((map_reg[PPR_IDX_OUT0 + 4'h3] & ~PPR_MASK_BOTH6)
      == 16'h0000) else $error("out3 unimpl bit set");
   AST_UNIMPL_OUT4: assert property ((map_reg[PPR_IDX_OUT0 + 4'h4] & ~PPR_MASK_BOTH6)
      == 16'h0000) else $error("out4 unimpl bit set");
   AST_UNIMPL_OUT5: assert property ((map_reg[PPR_IDX_OUT0 + 4'h5] & ~PPR_MASK_BOTH6)
      == 16'h0000) else $error("out5 unimpl bit set");
   AST_UNIMPL_OUT6: assert property ((map_reg[PPR_IDX_OUT0 + 4'h6] & ~PPR_MASK_BOTH6)
      == 16'h0000) else $error("out6 unimpl bit set");
   AST_UNIMPL_OUT7: assert property ((map_reg[PPR_IDX_OUT7] & ~PPR_MASK_HI6)
      == 16'h0000) else $error("pin97 map unimpl bit set");
   AST_UNIMPL_OUT8: assert property ((map_reg[PPR_IDX_OUT8] & ~PPR_MASK_HI6)
      == 16'h0000) else $error("pin118 map unimpl bit set");

   // ****************************************************
   // Input routing checks
   // ****************************************************
   AST_SYNC_PINS: assert property (1'b1 |=> pin_sync_reg == $past(pin_meta_reg))
      else $error("pin sync chain");
   AST_SYNC_CMP: assert property (1'b1 |=> cmp_sync_reg == $past(cmp_meta_reg))
      else $error("cmp sync chain");

   // Encoding written apart from route_in, so a slip there shows
   property in_route_p(logic [6:0] code, logic dout);
      1'b1 |=> dout == (($past(code) == PPR_SEL_GND) ? 1'b0 :
         ($past(code) == PPR_SEL_CMP) ? $past(cmp_sync_reg) :
         ($past(code) > PPR_SEL_PIN121) ? 1'b0 : $past(pin_sync_reg[code]));
   endproperty

   AST_IN_SPI2: assert property (in_route_p(map_reg[PPR_IDX_SPI2][6:0],
      periph_in_o.spi2_slave_select_input)) else $error("spi2 route");
   AST_IN_CAN1: assert property (in_route_p(map_reg[PPR_IDX_CAN1][6:0],
      periph_in_o.can1_receive_input)) else $error("can1 route");
   AST_IN_SYNC: assert property (in_route_p(map_reg[PPR_IDX_SYNC][14:8],
      periph_in_o.pwm_sync_input)) else $error("pwm sync route");
   AST_IN_DTC1: assert property (in_route_p(map_reg[PPR_IDX_DTC1][14:8],
      periph_in_o.deadtime_comp_input[0])) else $error("dtc1 route");
   AST_IN_DTC2: assert property (in_route_p(map_reg[PPR_IDX_DTC23][6:0],
      periph_in_o.deadtime_comp_input[1])) else $error("dtc2 route");
   AST_IN_DTC3: assert property (in_route_p(map_reg[PPR_IDX_DTC23][14:8],
      periph_in_o.deadtime_comp_input[2])) else $error("dtc3 route");

   // ****************************************************
   // Output routing checks
   // ****************************************************
   // Port-owned pins drive low and drop their enable
   property out_route_p(logic [5:0] code, logic en, logic dout);
      1'b1 |=> en == ($past(code) != PPR_FN_PORT)
         && dout == ($past(code) != PPR_FN_PORT && $past(func_out_i[code]));
   endproperty

   AST_OUT_P20: assert property (out_route_p(map_reg[PPR_IDX_OUT0][5:0],
      pin_remap_en_o[0], pin_out_o[0])) else $error("pin20 route");
   AST_OUT_P35: assert property (out_route_p(map_reg[PPR_IDX_OUT0][13:8],
      pin_remap_en_o[1], pin_out_o[1])) else $error("pin35 route");
   AST_OUT_P36: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h1][5:0],
      pin_remap_en_o[2], pin_out_o[2])) else $error("pin36 route");
   AST_OUT_P37: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h1][13:8],
      pin_remap_en_o[3], pin_out_o[3])) else $error("pin37 route");
   AST_OUT_P38: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h2][5:0],
      pin_remap_en_o[4], pin_out_o[4])) else $error("pin38 route");
   AST_OUT_P39: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h2][13:8],
      pin_remap_en_o[5], pin_out_o[5])) else $error("pin39 route");
   AST_OUT_P40: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h3][5:0],
      pin_remap_en_o[6], pin_out_o[6])) else $error("pin40 route");
   AST_OUT_P41: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h3][13:8],
      pin_remap_en_o[7], pin_out_o[7])) else $error("pin41 route");
   AST_OUT_P42: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h4][5:0],
      pin_remap_en_o[8], pin_out_o[8])) else $error("pin42 route");
   AST_OUT_P43: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h4][13:8],
      pin_remap_en_o[9], pin_out_o[9])) else $error("pin43 route");
   AST_OUT_P54: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h5][5:0],
      pin_remap_en_o[10], pin_out_o[10])) else $error("pin54 route");
   AST_OUT_P55: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h5][13:8],
      pin_remap_en_o[11], pin_out_o[11])) else $error("pin55 route");
   AST_OUT_P56: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h6][5:0],
      pin_remap_en_o[12], pin_out_o[12])) else $error("pin56 route");
   AST_OUT_P57: assert property (out_route_p(map_reg[PPR_IDX_OUT0 + 4'h6][13:8],
      pin_remap_en_o[13], pin_out_o[13])) else $error("pin57 route");
   AST_OUT_P97: assert property (out_route_p(map_reg[PPR_IDX_OUT7][13:8],
      pin_remap_en_o[14], pin_out_o[14])) else $error("pin97 route");
   AST_OUT_P118: assert property (out_route_p(map_reg[PPR_IDX_OUT8][13:8],
      pin_remap_en_o[15], pin_out_o[15])) else $error("pin118 route");
   AST_OUT_P120: assert property (out_route_p(map_reg[PPR_IDX_OUT9][5:0],
      pin_remap_en_o[16], pin_out_o[16])) else $error("pin120 route");
   // Spare slot has no select field, so it must stay with the port
   AST_OUT_SPARE: assert property (!pin_remap_en_o[17] && !pin_out_o[17])
      else $error("spare slot driven");
endmodule

/* File: tb/ppr_far_model.sv */
/*
 Far-side model: remappable pin levels, the comparator and the peripheral
 output functions, all taken from one pattern held by the bench.
 Assumes the bench changes the pattern just after a rising clock edge.
*/
`timescale 1ns/1ps
module ppr_far_model (
   input wire logic clk_i,
   input wire logic [63:0] pat_i,
   output logic [127:0] pin_o,
   output logic cmp_o,
   output logic [63:0] func_o
);
   // Registered so every pin moves on one edge
   always_ff @(posedge clk_i) begin
      pin_o <= {pat_i, ~pat_i};
      cmp_o <= pat_i[0] ^ pat_i[63];
      func_o <= {pat_i[31:0], pat_i[63:32]};
   end
endmodule

/* File: tb/testbench.sv */
/*
 Testbench for the remap slice: register map over Wishbone, input routing
 and output routing. Assumes the far-side model feeds pins and functions.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench;
   import ppr_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [3:0] sel = 4'h3;
   logic [5:0] ivec;
   logic [31:0] dat = 32'h0, rd, dato;
   logic ack;
   logic [63:0] pat = 64'h0, fn;
   logic [127:0] pins;
   logic cmp;
   ppr_in_t pin_s;
   logic [17:0] pout, pen;
   logic [15:0] lfsr = 16'h0037, v;
   logic [5:0] code [17];
   int n_fail = 0, total_checks = 0;
   // ****************
   // Harness
   // ****************
   initial forever #20 clk_i = ~clk_i;
   ppr_far_model u_ppr_far_model (.clk_i(clk_i), .pat_i(pat), .pin_o(pins), .cmp_o(cmp),
      .func_o(fn));
   ppr_remap u_ppr_remap (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
      .wb_ack_o(ack), .remappable_pin_i(pins), .first_comparator_output_i(cmp),
      .func_out_i(fn), .periph_in_o(pin_s), .pin_out_o(pout), .pin_remap_en_o(pen));
   function automatic logic [15:0] rmask(input int r);
      if (r < 2) return PPR_MASK_LO7;
      if (r < 4) return PPR_MASK_HI7;
      if (r == 4) return PPR_MASK_BOTH7;
      if (r < 12) return PPR_MASK_BOTH6;
      if (r < 14) return PPR_MASK_HI6;
      return (r == 14) ? PPR_MASK_LO6 : 16'h0000;
   endfunction
   function automatic logic exp_in(input logic [6:0] c);
      if (c == PPR_SEL_GND) return 1'b0;
      if (c == PPR_SEL_CMP) return cmp;
      return (c <= PPR_SEL_PIN121) ? pins[c] : 1'b0;
   endfunction
   task automatic rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v = lfsr;
   endtask
   task automatic wb(input int r, input logic w, input logic [15:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= 6'(r * 4);
      dat <= {16'h0, d};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = dato;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic end_sim();
      if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      end_sim();
   end
   // ****************
   // Scenarios
   // ****************
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Reset value, then all ones; 15 is unmapped
      for (int r = 0; r < 16; r++) begin
         wb(r, 1'b0, 16'h0);
         `CHK(rd, 32'h0)
         wb(r, 1'b1, 16'hffff);
         wb(r, 1'b0, 16'h0);
         `CHK(rd, {16'h0, rmask(r)})
      end
      // Byte lanes: only enabled lanes of register 4 change
      sel <= 4'h1;
      wb(4, 1'b1, 16'h0000);
      sel <= 4'h3;
      wb(4, 1'b0, 16'h0);
      `CHK(rd, {16'h0, PPR_MASK_BOTH7 & 16'hff00})
      sel <= 4'h2;
      wb(4, 1'b1, 16'h0000);
      sel <= 4'h3;
      wb(4, 1'b0, 16'h0);
      `CHK(rd, 32'h0)
      // Field f: 0 spi2, 1 can1, 2 sync, 3..5 dead-time; codes 0, 1, 121, mid, 122
      for (int f = 0; f < 6; f++) begin
         for (int k = 0; k < 5; k++) begin
            logic [6:0] c;
            int r;
            rnd();
            c = (k == 3) ? 7'(v % 120 + 2) : (k == 2) ? PPR_SEL_PIN121 : 7'(k == 4 ? 122 : k);
            r = (f == 5) ? 4 : (f == 4) ? 4 : f;
            wb(r, 1'b1, (f == 2 || f == 3 || f == 5) ? {1'b0, c, 8'h0} : {9'h0, c});
            pat <= {v, ~v, v ^ 16'h5a5a, 7'h0, v[8:0]};
            repeat (6) @(posedge clk_i);
            ivec = {pin_s.deadtime_comp_input, pin_s.pwm_sync_input, pin_s.can1_receive_input,
               pin_s.spi2_slave_select_input};
            `CHK(ivec[f], exp_in(c))
         end
      end
      // Output maps: random codes per register
      for (int r = 5; r < 15; r++) begin
         rnd();
         wb(r, 1'b1, v);
         if (r < 12) begin
            code[2 * (r - 5)] = v[5:0];
            code[2 * (r - 5) + 1] = v[13:8];
         end else begin
            code[r + 2] = (r == 14) ? v[5:0] : v[13:8];
         end
         pat <= {v, v ^ 16'hc3c3, ~v, v};
         repeat (3) @(posedge clk_i);
         for (int j = 0; j <= 2 * (r - 5) + 1 && j < 17; j++) begin
            if (r < 12 || j == r + 2) begin
               `CHK(pen[j], code[j] != PPR_FN_PORT)
               if (code[j] != PPR_FN_PORT) `CHK(pout[j], fn[code[j]])
               else `CHK(pout[j], 1'b0)
            end
         end
         `CHK(pen[17], 1'b0)
         `CHK(pout[17], 1'b0)
      end
      end_sim();
   end
endmodule
